// ==== rtl/ssc_pkg.sv ====
package ssc_pkg;
   // Array geometry
   localparam int ADDR_W = 23;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BURST_W = 2;
   localparam int HI_W = ADDR_W - BURST_W;

   // Positions of the asynchronous and mode pins in the synchroniser
   localparam int PIN_SLEEP = 0;
   localparam int PIN_ORDER = 1;
   localparam int PIN_BYPASS = 2;
   localparam int PIN_DRIVE = 3;
   localparam int PIN_OE = 4;
   localparam int PIN_NUM = 5;
   // Pull defaults: sleep low, linear, pipelined, reduced drive, oe off
   localparam logic [PIN_NUM-1:0] PIN_RESET = 5'h1c;

   // Sleep entry and wake-up, given in cycles
   localparam int SLEEP_ENTRY_TIME = 2;
   localparam int SLEEP_RECOVERY_TIME = 2;
   localparam logic [1:0] SLEEP_ENTRY_LAST = 2'(SLEEP_ENTRY_TIME - 1);
   localparam logic [1:0] SLEEP_RECOVERY_LAST =
      2'(SLEEP_RECOVERY_TIME - 1);

   typedef enum logic [3:0] {
      SSC_AWAKE = 4'h1,
      SSC_ENTERING = 4'h2,
      SSC_ASLEEP = 4'h4,
      SSC_WAKING = 4'h8
   } ssc_sleep_t;

   // Kind of the last command taken, as the status port shows it
   typedef enum logic [3:0] {
      SSC_CMD_NONE = 4'h0,
      SSC_CMD_READ = 4'h1,
      SSC_CMD_WRITE = 4'h2,
      SSC_CMD_CONT = 4'h4,
      SSC_CMD_DESEL = 4'h8
   } ssc_cmd_t;

   // Reset values of the controller state
   localparam ssc_sleep_t SLEEP_RESET = SSC_AWAKE;
   localparam logic DESEL_RESET = 1'b1;
   localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
endpackage

// ==== rtl/ssc_sync.sv ====
`timescale 1ns/1ps
module ssc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Raw pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ssc_sync_state_t;

   ssc_sync_state_t st;
   ssc_sync_state_t next_st;
   logic [W-1:0] agreed;

   // A level only counts once the last two stages agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      assign agreed[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.q[i];
   end

   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.q = agreed;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= {RESET, RESET, RESET, RESET};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign level_out = st.q;
endmodule

// ==== rtl/ssc_burst.sv ====
`timescale 1ns/1ps
module ssc_burst (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Load and step, already qualified by the controller
   input wire logic load_en,
   input wire logic step_en,
   input wire logic [ssc_pkg::BURST_W-1:0] load_low,
   input wire logic interleave,
   // Low address bits of the next continue cycle
   output logic [ssc_pkg::BURST_W-1:0] low_step
);
   typedef struct packed {
      logic [ssc_pkg::BURST_W-1:0] start;
      logic [ssc_pkg::BURST_W-1:0] count;
   } ssc_burst_state_t;

   ssc_burst_state_t st;
   ssc_burst_state_t next_st;
   logic [ssc_pkg::BURST_W-1:0] count_up;

   // Two bits wrap by themselves, so the fifth clock is back at the start
   assign count_up = st.count + ssc_pkg::BURST_ONE;
   assign low_step = interleave ? (st.start ^ count_up)
                                : (st.start + count_up);

   always_comb
   begin
      next_st = st;
      if (load_en)
      begin
         next_st.start = load_low;
         next_st.count = ssc_pkg::BURST_RESET;
      end
      else if (step_en)
      begin
         next_st.count = count_up;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= {ssc_pkg::BURST_RESET, ssc_pkg::BURST_RESET};
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule

// ==== rtl/ssc_sram_control.sv ====
`timescale 1ns/1ps
// How it works
// - Selected, loading, write strobe high: load address, start read burst.
// - Read with output drive off touches no array and floats the bus.
// - Selected, loading, write strobe low, any lane on: start write burst.
// - Write strobe low with no lane on aborts: nothing written, bus floats.
// - Step cycles use counter address, keep direction, lanes pick write/abort.
// - Loading with any select inactive deselects, no access, bus floats.
// - Step after a deselect stays deselected with bus floating.
// - Gated clock edge is ignored; all address and pipeline state holds.
// - Gated during read keeps driving; during write bus stays floating.
// - Outputs off in write data cycles; output control gates asynchronously.
// - After power-up all outputs float until a command is taken.
// - Two-bit burst counter steps each continue, wraps on fifth clock.
// - Burst order low: low address bits count up modulo four.
// - Burst order high: start XOR a count of zero to three.
// - Bypass low is flow-through; defaults pipelined, reduced drive, awake.
// - Drive select low gives nominal drive, high or open gives reduced.
// - Sleep entered two cycles after request; wake takes two cycles.
// - Asleep: inputs ignored except sleep and drive select, all outputs float.
// - Pipelined: write data on third edge, read data one edge later.
// - Flow-through: write data on second edge, read data right away.
// - Each active-low lane strobe writes its own nine-bit lane.
module ssc_sram_control (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Synchronous command pins
   input wire logic clock_gate_n,
   input wire logic burst_step_load_n,
   input wire logic write_n,
   input wire logic [ssc_pkg::LANES-1:0] byte_lane_strobe_n,
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic select_three_n,
   input wire logic [ssc_pkg::ADDR_W-1:0] address,
   // Asynchronous and mode pins
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_select,
   input wire logic output_register_bypass_n,
   input wire logic drive_strength_select,
   // Data bus
   input wire logic [ssc_pkg::DATA_W-1:0] dq_in,
   output logic [ssc_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   // Status
   output logic drive_nominal,
   output logic sleep_active,
   output logic [3:0] last_command,
   // Array read port, data returned in the same cycle
   output logic array_re,
   output logic [ssc_pkg::ADDR_W-1:0] array_raddr,
   input wire logic [ssc_pkg::DATA_W-1:0] array_rdata,
   // Array write port, one enable per lane
   output logic [ssc_pkg::LANES-1:0] array_we,
   output logic [ssc_pkg::ADDR_W-1:0] array_waddr,
   output logic [ssc_pkg::DATA_W-1:0] array_wdata
);
   // All controller state lives in one record; the counter and the pin
   // filter keep their own; a stall freezes the counter, the filter keeps sampling
   typedef struct packed {
      ssc_pkg::ssc_sleep_t sleep_st;
      logic [1:0] sleep_cnt;
      logic desel;
      logic burst_wr;
      logic [ssc_pkg::HI_W-1:0] addr_hi;
      ssc_pkg::ssc_cmd_t cmd;
      logic rd1;
      logic rd2;
      logic [ssc_pkg::DATA_W-1:0] dq_q;
      logic wr1;
      logic [ssc_pkg::LANES-1:0] wr1_lanes;
      logic [ssc_pkg::ADDR_W-1:0] wr1_addr;
      logic wr2;
      logic [ssc_pkg::LANES-1:0] wr2_lanes;
      logic [ssc_pkg::ADDR_W-1:0] wr2_addr;
      logic re;
      logic [ssc_pkg::ADDR_W-1:0] raddr;
      logic [ssc_pkg::LANES-1:0] we;
      logic [ssc_pkg::ADDR_W-1:0] waddr;
      logic [ssc_pkg::DATA_W-1:0] wdata;
      logic drive_nom;
   } ssc_ctrl_state_t;

   ssc_ctrl_state_t st;
   ssc_ctrl_state_t next_st;

   logic [ssc_pkg::PIN_NUM-1:0] pins_raw;
   logic [ssc_pkg::PIN_NUM-1:0] pins;
   logic sleep_seen;
   logic pipelined;
   logic oe_seen;
   logic edge_live;
   logic selected;
   logic lane_any;
   logic [ssc_pkg::LANES-1:0] lanes_on;
   logic [ssc_pkg::BURST_W-1:0] low_step;
   logic [ssc_pkg::ADDR_W-1:0] step_addr;
   logic burst_load;
   logic burst_step;
   logic wr_due;
   logic [ssc_pkg::LANES-1:0] wr_due_lanes;
   logic [ssc_pkg::ADDR_W-1:0] wr_due_addr;
   logic read_drive;
   logic asleep;

   // Sleep and output control are asynchronous; the mode pins are
   // static straps but go through the same filter for safety
   assign pins_raw[ssc_pkg::PIN_SLEEP] = sleep_request;
   assign pins_raw[ssc_pkg::PIN_ORDER] = burst_order_select;
   assign pins_raw[ssc_pkg::PIN_BYPASS] = output_register_bypass_n;
   assign pins_raw[ssc_pkg::PIN_DRIVE] = drive_strength_select;
   assign pins_raw[ssc_pkg::PIN_OE] = output_enable_n;

   // Reset value stands in for the pull-ups and pull-down
   ssc_sync #(
      .W(ssc_pkg::PIN_NUM),
      .RESET(ssc_pkg::PIN_RESET)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .pin_in(pins_raw),
      .level_out(pins)
   );

   assign sleep_seen = pins[ssc_pkg::PIN_SLEEP];
   assign pipelined = pins[ssc_pkg::PIN_BYPASS];
   assign oe_seen = !pins[ssc_pkg::PIN_OE];
   assign asleep = (st.sleep_st == ssc_pkg::SSC_ASLEEP);

   // A gated edge and a sleeping device look the same to the decode:
   // nothing below moves, so a wait state needs no state of its own
   assign edge_live = !clock_gate_n && !asleep;
   // Any one inactive select is enough to deselect
   assign selected = !select_one_n && select_two && !select_three_n;
   assign lanes_on = ~byte_lane_strobe_n;
   assign lane_any = |lanes_on;
   assign step_addr = {st.addr_hi, low_step};

   // Write data is taken one edge later in pipelined mode
   assign wr_due = pipelined ? st.wr2 : st.wr1;
   assign wr_due_lanes = pipelined ? st.wr2_lanes : st.wr1_lanes;
   assign wr_due_addr = pipelined ? st.wr2_addr : st.wr1_addr;
   assign read_drive = pipelined ? st.rd2 : st.rd1;

   // The counter sees the order pin after the filter, like the rest
   ssc_burst u_burst (
      .clk(clk),
      .rstn(rstn),
      .load_en(burst_load),
      .step_en(burst_step),
      .load_low(address[ssc_pkg::BURST_W-1:0]),
      .interleave(pins[ssc_pkg::PIN_ORDER]),
      .low_step(low_step)
   );

   always_comb
   begin
      next_st = st;
      burst_load = 1'b0;
      burst_step = 1'b0;
      // A lane write is a single pulse, never repeated by a stall
      next_st.we = '0;
      next_st.drive_nom = !pins[ssc_pkg::PIN_DRIVE];

      // Sleep runs whatever the clock gate does
      // A request that drops before the entry count ends leaves the device
      // awake, so a glitch on the pin costs no wake-up time
      unique case (st.sleep_st)
         ssc_pkg::SSC_AWAKE:
         begin
            if (sleep_seen)
            begin
               next_st.sleep_st = ssc_pkg::SSC_ENTERING;
               next_st.sleep_cnt = '0;
            end
         end
         ssc_pkg::SSC_ENTERING:
         begin
            if (!sleep_seen)
            begin
               next_st.sleep_st = ssc_pkg::SSC_AWAKE;
            end
            else if (st.sleep_cnt == ssc_pkg::SLEEP_ENTRY_LAST)
            begin
               next_st.sleep_st = ssc_pkg::SSC_ASLEEP;
            end
            else
            begin
               next_st.sleep_cnt = st.sleep_cnt + 2'h1;
            end
         end
         ssc_pkg::SSC_ASLEEP:
         begin
            if (!sleep_seen)
            begin
               next_st.sleep_st = ssc_pkg::SSC_WAKING;
               next_st.sleep_cnt = '0;
            end
         end
         ssc_pkg::SSC_WAKING:
         begin
            if (sleep_seen)
            begin
               next_st.sleep_st = ssc_pkg::SSC_ASLEEP;
            end
            else if (st.sleep_cnt == ssc_pkg::SLEEP_RECOVERY_LAST)
            begin
               next_st.sleep_st = ssc_pkg::SSC_AWAKE;
            end
            else
            begin
               next_st.sleep_cnt = st.sleep_cnt + 2'h1;
            end
         end
         default:
         begin
            next_st.sleep_st = ssc_pkg::SSC_AWAKE;
         end
      endcase

      // Everything below holds still on a gated edge or while asleep
      if (edge_live)
      begin
         if (wr_due)
         begin
            next_st.we = wr_due_lanes;
            next_st.waddr = wr_due_addr;
            next_st.wdata = dq_in;
         end
         next_st.wr2 = st.wr1 && pipelined;
         next_st.wr2_lanes = st.wr1_lanes;
         next_st.wr2_addr = st.wr1_addr;
         next_st.rd2 = st.rd1 && pipelined;
         // Pipelined data is captured on the edge after the read issued
         if (st.rd1)
         begin
            next_st.dq_q = array_rdata;
         end
         // Issue slots are one-cycle pulses; the decode below sets them again
         next_st.wr1 = 1'b0;
         next_st.rd1 = 1'b0;
         next_st.re = 1'b0;

         if (!burst_step_load_n)
         begin
            if (!selected)
            begin
               next_st.desel = 1'b1;
               next_st.cmd = ssc_pkg::SSC_CMD_DESEL;
            end
            else if (write_n)
            begin
               // Dummy read still loads the address and counter
               next_st.desel = 1'b0;
               next_st.burst_wr = 1'b0;
               next_st.addr_hi = address[ssc_pkg::ADDR_W-1:ssc_pkg::BURST_W];
               burst_load = 1'b1;
               next_st.rd1 = oe_seen;
               next_st.re = oe_seen;
               next_st.raddr = address;
               next_st.cmd = ssc_pkg::SSC_CMD_READ;
            end
            else if (lane_any)
            begin
               next_st.desel = 1'b0;
               next_st.burst_wr = 1'b1;
               next_st.addr_hi = address[ssc_pkg::ADDR_W-1:ssc_pkg::BURST_W];
               burst_load = 1'b1;
               next_st.wr1 = 1'b1;
               next_st.wr1_lanes = lanes_on;
               next_st.wr1_addr = address;
               next_st.cmd = ssc_pkg::SSC_CMD_WRITE;
            end
            else
            begin
               // An aborted write start counts as a deselect
               next_st.desel = 1'b1;
               next_st.cmd = ssc_pkg::SSC_CMD_DESEL;
            end
         end
         else if (st.desel)
         begin
            next_st.cmd = ssc_pkg::SSC_CMD_DESEL;
         end
         else
         begin
            // Limitation: a write issued during wake-up is still carried
            // out; the controller is trusted not to issue one
            // Counter steps even when the lanes abort the cycle
            burst_step = 1'b1;
            next_st.cmd = ssc_pkg::SSC_CMD_CONT;
            if (st.burst_wr)
            begin
               next_st.wr1 = lane_any;
               next_st.wr1_lanes = lanes_on;
               next_st.wr1_addr = step_addr;
            end
            else
            begin
               next_st.rd1 = oe_seen;
               next_st.re = oe_seen;
               next_st.raddr = step_addr;
            end
         end
      end
   end

   // Reset leaves the device deselected and every output quiet, so the
   // bus floats until the first command is taken
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.sleep_st <= ssc_pkg::SLEEP_RESET;
         st.desel <= ssc_pkg::DESEL_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // The output control pin acts without the clock; write data cycles
   // never overlap a read's drive slot, the extra term is a safeguard
   assign dq_oe = read_drive && !output_enable_n && !asleep
                  && !wr_due;
   // Flow-through passes the array straight out, pipelined is registered
   assign dq_out = pipelined ? st.dq_q : array_rdata;

   // Status and array ports other than sleep_active are plain register copies, so nothing
   // downstream sees a combinational glitch from the decode
   assign drive_nominal = st.drive_nom;
   assign sleep_active = asleep;
   assign last_command = st.cmd;
   assign array_re = st.re;
   assign array_raddr = st.raddr;
   assign array_we = st.we;
   assign array_waddr = st.waddr;
   assign array_wdata = st.wdata;
endmodule

// ==== verif/ssc_array_model.sv ====
`timescale 1ns/1ps
module ssc_array_model (
   // Clock
   input logic clk,
   // Read port, answered in the same cycle
   input logic array_re,
   input logic [ssc_pkg::ADDR_W-1:0] array_raddr,
   output logic [ssc_pkg::DATA_W-1:0] array_rdata,
   // Write port
   input logic [ssc_pkg::LANES-1:0] array_we,
   input logic [ssc_pkg::ADDR_W-1:0] array_waddr,
   input logic [ssc_pkg::DATA_W-1:0] array_wdata
);
   logic [ssc_pkg::DATA_W-1:0] mem [logic [ssc_pkg::ADDR_W-1:0]];
   logic [ssc_pkg::DATA_W-1:0] word;
   // Unwritten words read back as their own address
   always @*
   begin
      word = 36'(array_raddr);
      if (mem.exists(array_raddr))
         word = mem[array_raddr];
      // Idle port shows the inverse so stale data never looks valid
      array_rdata = array_re ? word : ~word;
   end
   always @(posedge clk)
      for (int i = 0; i < ssc_pkg::LANES; i++)
         if (array_we[i])
         begin
            if (!mem.exists(array_waddr))
               mem[array_waddr] = 36'(array_waddr);
            mem[array_waddr][i*9 +: 9] = array_wdata[i*9 +: 9];
         end
endmodule

// ==== verif/ssc_sram_control_props.sv ====
`timescale 1ns/1ps
module ssc_sram_control_props (
   // Clock and reset
   input logic clk,
   input logic rstn,
   // Command pins
   input logic clock_gate_n,
   input logic burst_step_load_n,
   input logic write_n,
   input logic [ssc_pkg::LANES-1:0] byte_lane_strobe_n,
   input logic select_one_n,
   input logic select_two,
   input logic select_three_n,
   input logic [ssc_pkg::ADDR_W-1:0] address,
   // Asynchronous and mode pins
   input logic output_enable_n,
   input logic sleep_request,
   input logic burst_order_select,
   input logic output_register_bypass_n,
   input logic drive_strength_select,
   // Data bus and status
   input logic [ssc_pkg::DATA_W-1:0] dq_in,
   input logic [ssc_pkg::DATA_W-1:0] dq_out,
   input logic dq_oe,
   input logic drive_nominal,
   input logic sleep_active,
   input logic [3:0] last_command,
   // Array ports
   input logic array_re,
   input logic [ssc_pkg::ADDR_W-1:0] array_raddr,
   input logic [ssc_pkg::DATA_W-1:0] array_rdata,
   input logic [ssc_pkg::LANES-1:0] array_we,
   input logic [ssc_pkg::ADDR_W-1:0] array_waddr,
   input logic [ssc_pkg::DATA_W-1:0] array_wdata
);
   logic [1:0] mode_q;
   logic [2:0] mode_age;
   logic [ssc_pkg::ADDR_W-1:0] prev_raddr;
   logic prev_re;
   logic prev_gate_n;
   logic [ssc_pkg::DATA_W-1:0] lane_mask;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   always_comb
      for (int i = 0; i < ssc_pkg::LANES; i++)
         lane_mask[i*9 +: 9] = {9{array_we[i]}};
   // Mode pins pass a filter, so latency checks wait until they settle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= 2'h0;
         mode_age <= 3'h0;
         prev_raddr <= '0;
         prev_re <= 1'b0;
         prev_gate_n <= 1'b1;
      end
      else
      begin
         mode_q <= {burst_order_select, output_register_bypass_n};
         if (mode_q != {burst_order_select, output_register_bypass_n})
            mode_age <= 3'h0;
         else if (mode_age != 3'h7)
            mode_age <= mode_age + 3'h1;
         prev_raddr <= array_raddr;
         prev_re <= array_re;
         prev_gate_n <= clock_gate_n;
      end
   end
   reset_float_a: assert property (
      $rose(rstn) |-> !dq_oe && array_we == 4'h0 && !array_re)
      else $error("outputs active right after reset");
   oe_gates_bus_a: assert property (
      output_enable_n |-> !dq_oe)
      else $error("bus driven with output enable off");
   sleep_float_a: assert property (
      sleep_active |-> !dq_oe && !array_re && array_we == 4'h0)
      else $error("activity while asleep");
   drive_level_a: assert property (
      $stable(drive_strength_select) [*6]
      |-> drive_nominal == !drive_strength_select)
      else $error("drive strength does not follow its pin");
   pipe_read_a: assert property (
      array_re && !clock_gate_n && mode_age == 3'h7 && output_register_bypass_n
      |=> (dq_oe || output_enable_n) && dq_out == $past(array_rdata))
      else $error("pipelined read data not out one edge later");
   flow_read_a: assert property (
      array_re && mode_age == 3'h7 && !output_register_bypass_n
      |-> (dq_oe || output_enable_n) && dq_out == array_rdata)
      else $error("flow-through read data not out at once");
   write_data_a: assert property (
      array_we != 4'h0 |-> ((array_wdata ^ $past(dq_in)) & lane_mask) == '0)
      else $error("written lanes differ from sampled data");
   linear_step_a: assert property (
      array_re && prev_re && !prev_gate_n && last_command == 4'h4
      && mode_age == 3'h7 && !burst_order_select
      |-> array_raddr == {prev_raddr[22:2], prev_raddr[1:0] + 2'h1})
      else $error("linear burst step wrong");
   stall_hold_a: assert property (
      clock_gate_n && !sleep_request && !sleep_active
      |=> $stable(array_raddr) && $stable(last_command))
      else $error("state moved on a gated edge");
   sleep_enter_a: assert property (
      sleep_request [*8] |=> sleep_active)
      else $error("sleep not entered in time");
   sleep_exit_a: assert property (
      !sleep_request [*8] |=> !sleep_active)
      else $error("sleep not left in time");
endmodule
bind ssc_sram_control ssc_sram_control_props i_ssc_sram_control_props (.*);

// ==== verif/sync_burst_sram_control_bench.sv ====
`timescale 1ns/1ps
module sync_burst_sram_control_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic clock_gate_n = 1'b0;
   logic burst_step_load_n = 1'b0;
   logic write_n = 1'b1;
   logic [3:0] byte_lane_strobe_n = 4'hf;
   logic select_one_n = 1'b1;
   logic select_two = 1'b1;
   logic select_three_n = 1'b0;
   logic [22:0] address = 23'h0;
   logic output_enable_n = 1'b0;
   logic sleep_request = 1'b0;
   logic burst_order_select = 1'b0;
   logic output_register_bypass_n = 1'b1;
   logic drive_strength_select = 1'b1;
   logic [35:0] dq_in = 36'h0;
   logic [35:0] dq_out;
   logic dq_oe;
   logic drive_nominal;
   logic sleep_active;
   logic [3:0] last_command;
   logic array_re;
   logic [22:0] array_raddr;
   logic [35:0] array_rdata;
   logic [3:0] array_we;
   logic [22:0] array_waddr;
   logic [35:0] array_wdata;
   int errors = 0;
   int samples_checked = 0;
   logic [22:0] base;
   logic [22:0] prev;
   logic [35:0] d = 36'h987654321;
   // Order pin, start bits, then the four two-bit low address values expected
   logic [10:0] rows [8] = '{11'h01b, 11'h16c, 11'h2b1, 11'h3c6,
      11'h41b, 11'h54e, 11'h6b1, 11'h7e4};
   logic [2:0] desel [3] = '{3'h6, 3'h0, 3'h3};
   ssc_sram_control i_ssc_sram_control (.*);
   ssc_array_model i_ssc_array_model (.*);
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [35:0] seen, input logic [35:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   // Selects as {one_n, two, three_n}; called at a falling edge
   task automatic step(input logic [2:0] sel, input logic ld_n,
         input logic w_n, input logic [3:0] lanes, input logic [22:0] a);
      {select_one_n, select_two, select_three_n} = sel;
      burst_step_load_n = ld_n;
      write_n = w_n;
      byte_lane_strobe_n = lanes;
      address = a;
      @(negedge clk);
   endtask
   task automatic await(input logic want);
      int n;
      n = 0;
      while (sleep_active !== want && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      check(sleep_active, want);
      if (n == 40)
         complete_run();
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      check({dq_oe, array_re, array_we, sleep_active}, 7'h0);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      check(drive_nominal, 1'b0);
      for (int r = 0; r < 8; r++)
      begin
         burst_order_select = rows[r][10];
         repeat (6) step(3'h6, 0, 1, 4'hf, 23'h0);
         base = {21'h0a5c3 + 21'(r), rows[r][9:8]};
         for (int n = 0; n < 5; n++)
         begin
            step(3'h2, n != 0, n == 0, 4'h0, base);
            check(array_re, 1'b1);
            check(array_raddr, {base[22:2], rows[r][7-2*(n%4) -: 2]});
            if (n > 0)
               check({dq_oe, dq_out}, {1'b1, 13'h0, prev});
            prev = array_raddr;
         end
      end
      // Wait state in mid-burst keeps the bus driven and the address
      clock_gate_n = 1'b1;
      step(3'h2, 1, 1, 4'hf, 23'h0);
      check({dq_oe, array_raddr}, {1'b1, prev});
      clock_gate_n = 1'b0;
      foreach (desel[s])
      begin
         step(desel[s], 0, 1, 4'hf, 23'h4);
         check({array_re, last_command}, 5'h08);
         step(3'h2, 1, 0, 4'h0, 23'h0);
         check({array_re, dq_oe, last_command}, 6'h08);
      end
      step(3'h2, 0, 0, 4'ha, 23'h0777);
      check(dq_oe, 1'b0);
      step(3'h2, 1, 1, 4'hf, 23'h0);
      check(dq_oe, 1'b0);
      dq_in = d;
      step(3'h6, 0, 1, 4'hf, 23'h0);
      check({array_we, array_waddr}, {4'h5, 23'h0777});
      dq_in = ~d;
      step(3'h6, 0, 1, 4'hf, 23'h0);
      check(array_we, 4'h0);
      output_enable_n = 1'b1;
      repeat (4) step(3'h6, 0, 1, 4'hf, 23'h0);
      step(3'h2, 0, 1, 4'hf, 23'h0777);
      check({array_re, dq_oe}, 2'h0);
      step(3'h6, 0, 1, 4'hf, 23'h0);
      check(dq_oe, 1'b0);
      output_enable_n = 1'b0;
      output_register_bypass_n = 1'b0;
      burst_order_select = 1'b0;
      drive_strength_select = 1'b0;
      repeat (8) step(3'h6, 0, 1, 4'hf, 23'h0);
      check(drive_nominal, 1'b1);
      step(3'h2, 0, 1, 4'hf, 23'h0777);
      check({dq_oe, dq_out},
         {1'b1, (d & 36'h007fc01ff) | (36'h777 & ~36'h007fc01ff)});
      step(3'h2, 0, 0, 4'h0, 23'h0123);
      check(dq_oe, 1'b0);
      dq_in = d;
      step(3'h2, 1, 1, 4'h0, 23'h0);
      check({array_we, array_waddr}, {4'hf, 23'h0123});
      dq_in = ~d;
      step(3'h6, 0, 1, 4'hf, 23'h0);
      check({array_we, array_waddr}, {4'hf, 23'h0120});
      sleep_request = 1'b1;
      await(1'b1);
      step(3'h2, 0, 1, 4'hf, 23'h0777);
      check({array_re, dq_oe}, 2'h0);
      sleep_request = 1'b0;
      await(1'b0);
      step(3'h2, 0, 1, 4'hf, 23'h0777);
      check(array_re, 1'b1);
      complete_run();
   end
endmodule
